// ### design/dual_adc_ctrl_defs.vh
// constants for the dual converter serial read-out and power control
`ifndef DUAL_ADC_CTRL_DEFS_VH
`define DUAL_ADC_CTRL_DEFS_VH

// serial frame edge counts (serial clock falling edges after select falls)
`define GLITCH_EDGES      6'h02
`define POWER_KEEP_EDGES  6'h0A
`define TRACK_EDGES       6'h0D
`define CONV_EDGES        6'h0E
`define WORD_EDGES        6'h10
`define DUAL_END_EDGES    6'h20

// power states
`define PWR_NORMAL        2'h0
`define PWR_PARTIAL       2'h1
`define PWR_FULL          2'h2

// result field layout
`define RESULT_W          12
`define FIFO_W            24
`define FIFO_DEPTH        16
`define FIFO_AW           4
`define FIFO_FULL         5'h10

// wake time from partial power-down, ns, and cycles at 25 ns clock
`define WAKE_TIME_NS      1000
`define CLK_PERIOD_NS     25
// wake count loaded into a 6-bit counter: 1000 ns / 25 ns = 40
`define WAKE_CYCLES       6'h28

`endif

// ### design/result_fifo.v
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module result_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             resetn_i,
  input  wire             clk_en_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_valid_o && out_ready_i;

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (clk_en_i) begin
      if (do_wr) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end

endmodule // result_fifo

// ### design/dual_adc_serial_power_ctrl.v
// serial read-out and power-mode control of a dual sampling converter
`timescale 1ns/10ps
`include "dual_adc_ctrl_defs.vh"
module dual_adc_serial_power_ctrl (
  // clock, reset, enable
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  input  wire        clk_en_i,
  // serial link pins
  input  wire        chip_sel_n_i,
  input  wire        sclk_i,
  input  wire        serial_out_first_i,
  output reg         serial_out_first_o,
  output reg         serial_out_first_oe_n_o,
  input  wire        serial_out_second_i,
  output reg         serial_out_second_o,
  output reg         serial_out_second_oe_n_o,
  // configuration pins
  input  wire        input_config_select_i,
  input  wire [2:0]  channel_pair_select_i,
  input  wire        range_select_i,
  // converter core results, raw offset binary
  input  wire [11:0] conv_a_data_i,
  input  wire [11:0] conv_b_data_i,
  output reg         conv_in_ready_o,
  input  wire        conv_in_valid_i,
  // analog control
  output reg         track_hold_o,
  output reg         conv_start_o,
  output reg         conv_abort_o,
  output reg         analog_power_o,
  output reg         ref_power_o,
  output reg         powered_o,
  output reg  [1:0]  power_state_o,
  output reg         cfg_single_o,
  output reg  [2:0]  cfg_channel_o,
  output reg         cfg_range_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] cs_sync;
  reg [1:0] sck_sync;
  reg       cs_d;
  reg       sck_d;
  wire      cs_fall;
  wire      cs_rise;
  wire      sck_fall;
  wire      sck_rise;

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h3;
      cs_d     <= 1'b1;
      sck_d    <= 1'b1;
    end else if (clk_en_i) begin
      cs_sync  <= {cs_sync[0], chip_sel_n_i};
      sck_sync <= {sck_sync[0], sclk_i};
      cs_d     <= cs_sync[1];
      sck_d    <= sck_sync[1];
    end
  end

  assign cs_fall  = cs_d && !cs_sync[1];
  assign cs_rise  = !cs_d && cs_sync[1];
  assign sck_fall = sck_d && !sck_sync[1] && !cs_sync[1];
  assign sck_rise = !sck_d && sck_sync[1] && !cs_sync[1];

  // ----------------------------------------
  // result coding
  // ----------------------------------------
  function [11:0] code_word;
    input [11:0] raw;
    input        single;
    input        pseudo;
    input        range2;
    begin
      if ((single || pseudo) && !range2)
        code_word = raw;
      else
        code_word = {~raw[11], raw[10:0]};
    end
  endfunction

  // ----------------------------------------
  // result fifo between core and shifter
  // ----------------------------------------
  wire        fifo_valid;
  wire [23:0] fifo_data;
  reg         fifo_pop;

  // ----------------------------------------
  // registered input ready
  // ----------------------------------------
  // occupancy mirror so that the ready pin comes straight from a flop
  reg  [4:0]  fill;
  reg  [4:0]  next_fill;
  wire        fill_push;
  wire        fill_pop;

  assign fill_push = conv_in_valid_i && conv_in_ready_o;
  assign fill_pop  = fifo_pop && fifo_valid;

  always @* begin
    next_fill = fill;
    if (fill_push && !fill_pop)
      next_fill = fill + 5'h01;
    else if (fill_pop && !fill_push)
      next_fill = fill - 5'h01;
  end

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      fill            <= 5'h00;
      conv_in_ready_o <= 1'b1;
    end else if (clk_en_i) begin
      fill            <= next_fill;
      conv_in_ready_o <= (next_fill != `FIFO_FULL);
    end
  end

  result_fifo #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (fill_push),
    .in_ready_o  (),
    .in_data_i   ({conv_a_data_i, conv_b_data_i}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // ----------------------------------------
  // frame and power control
  // ----------------------------------------
  reg  [5:0]  edge_cnt;
  reg         active;
  reg         frame_wake;
  reg  [15:0] shift_a;
  reg  [15:0] shift_b;
  reg  [11:0] word_a;
  reg  [11:0] word_b;
  reg  [5:0]  wake_cnt;
  reg         cur_single;
  reg         cur_pseudo;
  reg         cur_range;
  wire        coded_pseudo;

  assign coded_pseudo = !cfg_single_o && cfg_channel_o[0];

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      edge_cnt                 <= 6'h00;
      active                   <= 1'b0;
      frame_wake               <= 1'b0;
      shift_a                  <= 16'h0000;
      shift_b                  <= 16'h0000;
      word_a                   <= 12'h000;
      word_b                   <= 12'h000;
      wake_cnt                 <= 6'h00;
      cur_single               <= 1'b1;
      cur_pseudo               <= 1'b0;
      cur_range                <= 1'b0;
      fifo_pop                 <= 1'b0;
      serial_out_first_o       <= 1'b0;
      serial_out_second_o      <= 1'b0;
      serial_out_first_oe_n_o  <= 1'b1;
      serial_out_second_oe_n_o <= 1'b1;
      track_hold_o             <= 1'b0;
      conv_start_o             <= 1'b0;
      conv_abort_o             <= 1'b0;
      analog_power_o           <= 1'b1;
      ref_power_o              <= 1'b1;
      powered_o                <= 1'b1;
      power_state_o            <= `PWR_NORMAL;
      cfg_single_o             <= 1'b1;
      cfg_channel_o            <= 3'h0;
      cfg_range_o              <= 1'b0;
    end else if (clk_en_i) begin
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
      fifo_pop     <= 1'b0;
      if (wake_cnt != 6'h00)
        wake_cnt <= wake_cnt - 6'h01;
      else if (power_state_o == `PWR_NORMAL && !active)
        powered_o <= 1'b1;
      if (cs_fall) begin
        track_hold_o             <= 1'b1;
        conv_start_o             <= 1'b1;
        active                   <= 1'b1;
        edge_cnt                 <= 6'h00;
        frame_wake               <= (power_state_o != `PWR_NORMAL);
        serial_out_first_oe_n_o  <= 1'b0;
        serial_out_second_oe_n_o <= 1'b0;
        serial_out_first_o       <= 1'b0;
        serial_out_second_o      <= 1'b0;
        analog_power_o           <= 1'b1;
        ref_power_o              <= 1'b1;
        cur_single               <= cfg_single_o;
        cur_pseudo               <= coded_pseudo;
        cur_range                <= cfg_range_o;
        cfg_single_o             <= input_config_select_i;
        cfg_channel_o            <= channel_pair_select_i;
        cfg_range_o              <= range_select_i;
      end else if (cs_rise && active) begin
        active                   <= 1'b0;
        track_hold_o             <= 1'b0;
        serial_out_first_oe_n_o  <= 1'b1;
        serial_out_second_oe_n_o <= 1'b1;
        if (edge_cnt < `CONV_EDGES)
          conv_abort_o <= 1'b1;
        if (edge_cnt < `GLITCH_EDGES) begin
          if (power_state_o == `PWR_PARTIAL)
            analog_power_o <= 1'b0;
          else if (power_state_o == `PWR_FULL) begin
            analog_power_o <= 1'b0;
            ref_power_o    <= 1'b0;
          end
        end else if (edge_cnt < `POWER_KEEP_EDGES) begin
          if (power_state_o == `PWR_NORMAL) begin
            power_state_o  <= `PWR_PARTIAL;
            analog_power_o <= 1'b0;
            powered_o      <= 1'b0;
          end else begin
            power_state_o  <= `PWR_FULL;
            analog_power_o <= 1'b0;
            ref_power_o    <= 1'b0;
            powered_o      <= 1'b0;
          end
        end
      end else if (active && sck_rise) begin
        if (edge_cnt == `TRACK_EDGES)
          track_hold_o <= 1'b0;
      end else if (active && sck_fall) begin
        edge_cnt <= edge_cnt + 6'h01;
        if (edge_cnt == 6'h00) begin
          serial_out_first_o  <= 1'b0;
          serial_out_second_o <= 1'b1;
          shift_a <= {code_word(fifo_data[23:12], cur_single, cur_pseudo, cur_range), 4'h0};
          shift_b <= {code_word(fifo_data[11:0], cur_single, cur_pseudo, cur_range), 4'h0};
          word_a  <= code_word(fifo_data[23:12], cur_single, cur_pseudo, cur_range);
          word_b  <= code_word(fifo_data[11:0], cur_single, cur_pseudo, cur_range);
          fifo_pop <= fifo_valid;
        end else if (edge_cnt == (`WORD_EDGES - 6'h01)) begin
          serial_out_first_o  <= 1'b0;
          serial_out_second_o <= 1'b0;
          shift_a <= {word_b, 4'h0};
          shift_b <= {word_a, 4'h0};
        end else if (edge_cnt == `WORD_EDGES) begin
          serial_out_first_o  <= 1'b1;
          serial_out_second_o <= 1'b0;
        end else if (edge_cnt == (`DUAL_END_EDGES - 6'h01)) begin
          serial_out_first_oe_n_o  <= 1'b1;
          serial_out_second_oe_n_o <= 1'b1;
          edge_cnt <= `DUAL_END_EDGES;
        end else if (edge_cnt < `DUAL_END_EDGES) begin
          serial_out_first_o  <= shift_a[15];
          serial_out_second_o <= shift_b[15];
          shift_a <= {shift_a[14:0], 1'b0};
          shift_b <= {shift_b[14:0], 1'b0};
        end else begin
          edge_cnt <= `DUAL_END_EDGES;
        end
        if (edge_cnt == (`POWER_KEEP_EDGES - 6'h01) && frame_wake) begin
          power_state_o <= `PWR_NORMAL;
          wake_cnt      <= `WAKE_CYCLES;
        end
      end
    end
  end

endmodule // dual_adc_serial_power_ctrl

// ### dv/adc_ctrl_monitor.sv
// concurrent checks on the read-out and power control ports
`timescale 1ns/10ps
`include "dual_adc_ctrl_defs.vh"
module adc_ctrl_monitor (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  // serial link
  input wire logic       chip_sel_n_i,
  input wire logic       sclk_i,
  input wire logic       serial_out_first_o,
  input wire logic       serial_out_first_oe_n_o,
  input wire logic       serial_out_second_oe_n_o,
  // analog control
  input wire logic       track_hold_o,
  input wire logic       conv_start_o,
  input wire logic       conv_abort_o,
  input wire logic       analog_power_o,
  input wire logic       ref_power_o,
  input wire logic [1:0] power_state_o
);
  logic       sclk_q;
  logic       cs_q;
  logic [5:0] fall_cnt;
  logic [3:0] hi_cnt;
  // counts raw clock falls per frame and idle cycles of select
  always @(posedge ref_clk_i) begin
    sclk_q <= sclk_i;
    cs_q   <= chip_sel_n_i;
    if (!resetn_i || (cs_q && !chip_sel_n_i)) fall_cnt <= 6'h00;
    else if (sclk_q && !sclk_i && !chip_sel_n_i && fall_cnt != 6'h3F) fall_cnt <= fall_cnt + 6'h01;
    if (!resetn_i || !chip_sel_n_i) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_start; $fell(chip_sel_n_i) |-> ##[1:5] conv_start_o; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_hold; $fell(chip_sel_n_i) |-> ##5 (track_hold_o && !serial_out_first_o
    && !serial_out_first_oe_n_o && !serial_out_second_oe_n_o); endproperty
  a_hold: assert property (p_hold) else $error("no hold or drive");
  property p_drive; (!chip_sel_n_i && $past(chip_sel_n_i, 6) == 1'b0 && fall_cnt < 6'h20)
    |-> !serial_out_first_oe_n_o && !serial_out_second_oe_n_o; endproperty
  a_drive: assert property (p_drive) else $error("output floated early");
  property p_float; (fall_cnt == 6'h20 && $past(fall_cnt) == 6'h1F)
    |-> ##[1:6] serial_out_first_oe_n_o && serial_out_second_oe_n_o; endproperty
  a_float: assert property (p_float) else $error("no float at edge 32");
  property p_rise; $rose(chip_sel_n_i)
    |-> ##[1:6] serial_out_first_oe_n_o && serial_out_second_oe_n_o; endproperty
  a_rise: assert property (p_rise) else $error("no float at select rise");
  property p_abort; ($rose(chip_sel_n_i) && fall_cnt < 6'h0E) |-> ##[1:6] conv_abort_o;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_partial; ($rose(chip_sel_n_i) && fall_cnt inside {[2:9]}
    && power_state_o == `PWR_NORMAL) |-> ##8 power_state_o == `PWR_PARTIAL; endproperty
  a_partial: assert property (p_partial) else $error("no partial power-down");
  property p_full; ($rose(chip_sel_n_i) && fall_cnt inside {[2:9]}
    && power_state_o == `PWR_PARTIAL) |-> ##8 power_state_o == `PWR_FULL; endproperty
  a_full: assert property (p_full) else $error("no full power-down");
  property p_wake; (fall_cnt == 6'h0A && $past(fall_cnt) == 6'h09
    && power_state_o != `PWR_NORMAL) |-> ##[1:6] power_state_o == `PWR_NORMAL; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_power; (hi_cnt == 4'hF && power_state_o != `PWR_NORMAL) |-> !analog_power_o
    && ref_power_o == (power_state_o == `PWR_PARTIAL); endproperty
  a_power: assert property (p_power) else $error("wrong analog power");
  property p_track; (fall_cnt == 6'h0D && $rose(sclk_i)) |-> ##[1:6] !track_hold_o;
  endproperty
  a_track: assert property (p_track) else $error("no return to track");
endmodule // adc_ctrl_monitor

// ### dv/host_port_model.sv
// serial port host model driving select and serial clock
`timescale 1ns/10ps
module host_port_model (
  // clock
  input  wire logic ref_clk_i,
  // serial link
  output logic      chip_sel_n_o,
  output logic      sclk_o
);
  initial begin
    chip_sel_n_o = 1'b1;
    sclk_o       = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic frame(input int n);
    chip_sel_n_o = 1'b0;
    wait_clk(6);
    repeat (n) begin
      sclk_o = 1'b0;
      wait_clk(4);
      sclk_o = 1'b1;
      wait_clk(4);
    end
    chip_sel_n_o = 1'b1;
    wait_clk(60);
  endtask
endmodule // host_port_model

// ### dv/testbench.sv
// self-checking bench for the dual converter read-out and power control
`timescale 1ns/10ps
`include "dual_adc_ctrl_defs.vh"
module testbench;
  logic        clk = 1'b0, resetn = 1'b0, cfg_sel = 1'b1, rng = 1'b0, in_valid = 1'b0;
  logic        p_sel = 1'b1, p_rng = 1'b0, p_ch0 = 1'b0;
  logic [2:0]  chan = 3'h0;
  logic [11:0] a_raw = 12'h000, b_raw = 12'h000, ca, cb;
  logic [15:0] lfsr = 16'h0042;
  logic [31:0] sf, ss;
  logic [1:0]  ps = `PWR_NORMAL;
  logic [2:0]  pw;
  wire         cs_n, sclk, o1, oe1, o2, oe2, rdy, pwrd, apw, rpw, csg, crg;
  wire  [1:0]  pst;
  wire  [2:0]  cch;
  logic [11:0] qa[$], qb[$];
  logic [1:0]  eq[$];
  int          n_errors = 0, num_checks = 0, n;
  int          nf[16] = '{32, 16, 14, 12, 1, 5, 1, 5, 11, 3, 10, 32, 9, 13, 2, 32};
  always #12.5 clk = ~clk;
  host_port_model host_i (.ref_clk_i(clk), .chip_sel_n_o(cs_n), .sclk_o(sclk));
  dual_adc_serial_power_ctrl dual_adc_serial_power_ctrl_i (
    .ref_clk_i(clk), .resetn_i(resetn), .clk_en_i(1'b1), .chip_sel_n_i(cs_n), .sclk_i(sclk),
    .serial_out_first_i(oe1 ? ~o1 : o1), .serial_out_first_o(o1), .serial_out_first_oe_n_o(oe1),
    .serial_out_second_i(oe2 ? ~o2 : o2), .serial_out_second_o(o2),
    .serial_out_second_oe_n_o(oe2), .input_config_select_i(cfg_sel),
    .channel_pair_select_i(chan), .range_select_i(rng), .conv_a_data_i(a_raw),
    .conv_b_data_i(b_raw), .conv_in_ready_o(rdy), .conv_in_valid_i(in_valid),
    .track_hold_o(), .conv_start_o(), .conv_abort_o(), .analog_power_o(apw), .ref_power_o(rpw),
    .powered_o(pwrd), .power_state_o(pst), .cfg_single_o(csg), .cfg_channel_o(cch),
    .cfg_range_o(crg));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge sclk) if (!cs_n && eq.size() > 0) begin
    check({oe1, oe2, o1, o2}, {2'b00, eq.pop_front()});
  end
  // rising-edge capture sees the bit that the next fall will also check
  always @(posedge sclk) if (!cs_n && eq.size() > 0) begin
    check({oe1, oe2, o1, o2}, {2'b00, eq[0]});
  end
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial begin
    host_i.wait_clk(10);
    resetn = 1'b1;
    host_i.wait_clk(5);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      a_raw = lfsr[11:0];
      b_raw = ~lfsr[15:4];
      in_valid = 1'b1;
      qa.push_back(a_raw);
      qb.push_back(b_raw);
      do @(posedge clk); while (rdy !== 1'b1);
      #1;
    end
    in_valid = 1'b0;
    host_i.wait_clk(2);
    check(rdy, 1'b0);
    for (int f = 0; f < 16; f++) begin
      n = nf[f];
      ca = qa.pop_front();
      cb = qb.pop_front();
      if (p_rng | (!p_sel & !p_ch0)) begin
        ca[11] = ~ca[11];
        cb[11] = ~cb[11];
      end
      sf = {2'b00, ca, 4'h1, cb, 2'b00};
      ss = {2'b01, cb, 4'h0, ca, 2'b00};
      for (int k = 0; k < n; k++) eq.push_back({sf[31-k], ss[31-k]});
      lfsr = lfsr_next(lfsr);
      rng = lfsr[4];
      cfg_sel = lfsr[3];
      chan = lfsr[2] ? {2'b10, lfsr[0]} : {1'b0, lfsr[1:0]};
      host_i.frame(n);
      check({crg, csg, cch}, {rng, cfg_sel, chan});
      {p_rng, p_sel, p_ch0} = {rng, cfg_sel, chan[0]};
      if (n >= 10) ps = `PWR_NORMAL;
      else if (n >= 2) ps = (ps == `PWR_NORMAL) ? `PWR_PARTIAL : `PWR_FULL;
      pw = (ps == `PWR_NORMAL) ? 3'h7 : (ps == `PWR_PARTIAL) ? 3'h1 : 3'h0;
      check({pst, pwrd, apw, rpw, oe1, oe2}, {ps, pw, 2'b11});
    end
    end_of_test();
  end
endmodule // testbench
bind dual_adc_serial_power_ctrl adc_ctrl_monitor adc_ctrl_monitor_i (.*);
